// ---- rtl/ocs_params.svh ----
// constants for the output control and status port
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH
`define OCS_CLK_MHZ      50
`define OCS_DEBOUNCE_US  5000
`define OCS_DEBOUNCE_CYC (`OCS_DEBOUNCE_US * `OCS_CLK_MHZ)
`define OCS_DB_CNT_W     18
`define OCS_BEEP_MS      100
`define OCS_BEEP_CYC     (`OCS_BEEP_MS * 1000 * `OCS_CLK_MHZ)
`define OCS_BEEP_CNT_W   23
`define OCS_PIN_W        4
`define OCS_PIN_IDLE     4'hb
`define OCS_STATUS_IDLE  5'h1f
`define OCS_CAUSE_NONE   3'h0
`define OCS_ERR_W        8
`define OCS_ERR_NONE     8'h00
`define OCS_ERR_SHUTDOWN 8'h4d
`define OCS_ADC_W        12
`define OCS_REF_W        16
`endif

// ---- rtl/ocs_pkg.sv ----
// types shared by the output control and status port
`include "ocs_params.svh"
package ocs_pkg;
  // raw port pins, in their electrical sense
  typedef struct packed {
    logic recallN;    // recall contact, low when closed
    logic isoOn;      // isolated on/off level, high when driven
    logic contactN;   // non-isolated on/off contact, low when closed
    logic shutdownN;  // shutdown input, low when shorted to common
  } ocs_pins_t;

  // open-collector status lines, all active low
  typedef struct packed {
    logic poweredN;
    logic alarmN;
    logic outOnN;
    logic ccN;
    logic cvN;
  } ocs_status_t;

  // latched alarm causes
  typedef struct packed {
    logic overVoltage;
    logic overCurrent;
    logic shutdown;
  } ocs_cause_t;

  typedef enum logic [1:0] {
    OCS_ST_OFF,
    OCS_ST_ON,
    OCS_ST_SHUT,
    OCS_ST_TRIP
  } ocs_out_state_t;
endpackage

// ---- rtl/ocs_debounce.sv ----
// two-flop synchroniser and debounce filter per port pin
`timescale 1ns/1ps
`include "ocs_params.svh"
module ocs_debounce #(
  parameter int STABLE_CYCLES = `OCS_DEBOUNCE_CYC
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [`OCS_PIN_W-1:0] rawIn,
  output logic      [`OCS_PIN_W-1:0] level
);
  localparam logic [`OCS_PIN_W-1:0]   IDLE = `OCS_PIN_IDLE;
  localparam logic [`OCS_DB_CNT_W-1:0] LAST = `OCS_DB_CNT_W'(STABLE_CYCLES - 1);

  genvar i;
  generate
    for (i = 0; i < `OCS_PIN_W; i++) begin : g_pin
      logic                     syncA_q;
      logic                     syncB_q;
      logic                     level_q;
      logic [`OCS_DB_CNT_W-1:0] cnt_q;
      logic                     differs;
      logic                     settled;

      assign differs = syncB_q != level_q;
      assign settled = cnt_q == LAST;

      // first flop feeds only the second
      always_ff @(posedge mclk) begin
        if (rst) begin
          syncA_q <= IDLE[i];
          syncB_q <= IDLE[i];
        end else begin
          syncA_q <= rawIn[i];
          syncB_q <= syncA_q;
        end
      end

      // level moves only after the pin has held still long enough
      always_ff @(posedge mclk) begin
        if (rst) begin
          cnt_q   <= '0;
          level_q <= IDLE[i];
        end else if (!differs) begin
          cnt_q <= '0;
        end else if (settled) begin
          cnt_q   <= '0;
          level_q <= syncB_q;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end

      assign level[i] = level_q;
    end
  endgenerate
endmodule

// ---- rtl/ocs_port.sv ----
// output on/off control, shutdown and status lines of the programming port
// Function
// RULE1: recall contact acts like front recall key
// RULE2: powered status low while unit is on
// RULE3: alarm status on trip or shutdown
// RULE4: output-on status when enabled by configuration
// RULE5: const_current_flag while loop in current mode
// RULE6: const_voltage_flag while loop in voltage mode
// RULE7: isolated positive level requests output on
// RULE8: non-isolated contact closed on, open off
// RULE9: either on/off input turns output on
// RULE10: external on/off ignored unless setting on
// RULE11: shutdown: off, beep, red led, error 77
// RULE12: shutdown overrides both on/off requests
// RULE13: external 0-10 V sets output voltage
// RULE14: external 0-10 V sets output current
// RULE15: pins synchronised, debounced; status registered
`timescale 1ns/1ps
`include "ocs_params.svh"
module ocs_port #(
  parameter int DEBOUNCE_CYCLES = `OCS_DEBOUNCE_CYC,
  parameter int BEEP_CYCLES     = `OCS_BEEP_CYC
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire ocs_pkg::ocs_pins_t      pinIn,
  input  wire logic                    unitOn,
  input  wire logic                    extOutputSwitchSetting,
  input  wire logic                    onStatusEnable,
  input  wire logic                    extVoltageProgramEnable,
  input  wire logic                    extCurrentProgramEnable,
  input  wire logic                    localOutputRequest,
  input  wire logic                    settingsRecallKey,
  input  wire logic                    overVoltageTrip,
  input  wire logic                    overCurrentTrip,
  input  wire logic                    alarmClear,
  input  wire logic                    constCurrentLoop,
  input  wire logic [`OCS_ADC_W-1:0]   extVoltageProgramIn,
  input  wire logic [`OCS_ADC_W-1:0]   extCurrentProgramIn,
  input  wire logic [`OCS_REF_W-1:0]   panelVoltSet,
  input  wire logic [`OCS_REF_W-1:0]   panelCurrSet,
  output ocs_pkg::ocs_status_t         statusOut,
  output logic                         outputEnable,
  output logic                         recallStrobe,
  output logic                         beepOn,
  output logic                         alarmLedOn,
  output logic                         errorStrobe,
  output logic [`OCS_ERR_W-1:0]        errorCode,
  output ocs_pkg::ocs_cause_t          alarmCause,
  output logic [`OCS_REF_W-1:0]        voltRef,
  output logic [`OCS_REF_W-1:0]        currRef
);
  import ocs_pkg::*;

  localparam logic [`OCS_BEEP_CNT_W-1:0] BEEP_LOAD = `OCS_BEEP_CNT_W'(BEEP_CYCLES);

  ocs_pins_t                  pinLevel;
  logic                       recallClosed;
  logic                       isoActive;
  logic                       contactClosed;
  logic                       shutdownActive;
  logic                       recallSeen_q;
  logic                       shutSeen_q;
  logic                       recallRise;
  logic                       shutRise;
  logic                       extRequest;
  logic                       onRequest;
  logic                       tripEvent;
  ocs_out_state_t             state_q;
  ocs_out_state_t             state_d;
  ocs_cause_t                 cause_q;
  ocs_cause_t                 cause_d;
  ocs_cause_t                 causeEvent;
  ocs_status_t                status_q;
  ocs_status_t                status_d;
  logic                       outputEnable_q;
  logic                       recallStrobe_q;
  logic                       errorStrobe_q;
  logic [`OCS_ERR_W-1:0]      errorCode_q;
  logic                       alarmLed_q;
  logic [`OCS_BEEP_CNT_W-1:0] beepCnt_q;
  logic [`OCS_BEEP_CNT_W-1:0] beepCnt_d;
  logic [`OCS_REF_W-1:0]      extVoltScaled;
  logic [`OCS_REF_W-1:0]      extCurrScaled;
  logic [`OCS_REF_W-1:0]      voltRef_q;
  logic [`OCS_REF_W-1:0]      currRef_q;
  logic                       outputEnable_d;
  logic                       alarmLed_d;
  logic                       recallStrobe_d;
  logic                       errorStrobe_d;
  logic [`OCS_ERR_W-1:0]      errorCode_d;
  logic                       beepOn_q;
  logic [`OCS_REF_W-1:0]      voltRef_d;
  logic [`OCS_REF_W-1:0]      currRef_d;

  // every port pin is synchronised and filtered before use
  ocs_debounce #(
    .STABLE_CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .mclk  (mclk),
    .rst   (rst),
    .rawIn (pinIn),
    .level (pinLevel)
  ); // RULE15

  // pin levels turned into active-high requests
  assign recallClosed   = ~pinLevel.recallN;
  assign isoActive      = pinLevel.isoOn;     // RULE7
  assign contactClosed  = ~pinLevel.contactN; // RULE8
  assign shutdownActive = ~pinLevel.shutdownN;

  // edge detection on the filtered contacts
  assign recallRise = recallClosed & ~recallSeen_q;
  assign shutRise   = shutdownActive & ~shutSeen_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      recallSeen_q <= 1'b0;
      shutSeen_q   <= 1'b0;
    end else begin
      recallSeen_q <= recallClosed;
      shutSeen_q   <= shutdownActive;
    end
  end

  // external on/off: either input, only when the setting allows it
  assign extRequest = extOutputSwitchSetting & (isoActive | contactClosed); // RULE9 RULE10
  // the external inputs take over from the local output key while enabled
  assign onRequest  = extOutputSwitchSetting ? extRequest : localOutputRequest; // RULE10
  assign tripEvent  = overVoltageTrip | overCurrentTrip;

  // output state: shutdown first, then trips, then the on request
  always_comb begin
    state_d = state_q;
    case (state_q)
      OCS_ST_OFF: begin
        if (shutdownActive) begin
          state_d = OCS_ST_SHUT; // RULE12
        end else if (tripEvent) begin
          state_d = OCS_ST_TRIP;
        end else if (onRequest && unitOn) begin
          state_d = OCS_ST_ON; // RULE7 RULE8 RULE9
        end
      end
      OCS_ST_ON: begin
        if (shutdownActive) begin
          state_d = OCS_ST_SHUT; // RULE11 RULE12
        end else if (tripEvent) begin
          state_d = OCS_ST_TRIP;
        end else if (!onRequest || !unitOn) begin
          state_d = OCS_ST_OFF; // RULE8
        end
      end
      OCS_ST_SHUT: begin
        // output stays off while shorted; afterwards the alarm waits for a clear
        if (!shutdownActive) begin
          state_d = OCS_ST_TRIP; // RULE12
        end
      end
      OCS_ST_TRIP: begin
        if (shutdownActive) begin
          state_d = OCS_ST_SHUT;
        end else if (alarmClear && !tripEvent) begin
          state_d = OCS_ST_OFF;
        end
      end
      default: begin
        state_d = OCS_ST_OFF;
      end
    endcase
  end

  // output state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= OCS_ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // power output follows the next state, so it drops on the same edge
  assign outputEnable_d = state_d == OCS_ST_ON; // RULE11 RULE12

  // registered enable keeps decode glitches away from the power stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      outputEnable_q <= 1'b0;
    end else begin
      outputEnable_q <= outputEnable_d;
    end
  end

  // alarm causes are sticky; a new event wins over a clear in the same cycle
  assign causeEvent.overVoltage = overVoltageTrip;
  assign causeEvent.overCurrent = overCurrentTrip;
  assign causeEvent.shutdown    = shutdownActive;
  assign cause_d = (alarmClear ? ocs_cause_t'(`OCS_CAUSE_NONE) : cause_q) | causeEvent; // RULE3
  assign alarmLed_d = |cause_d; // RULE11

  always_ff @(posedge mclk) begin
    if (rst) begin
      cause_q <= `OCS_CAUSE_NONE;
    end else begin
      cause_q <= cause_d;
    end
  end

  // red alarm lamp lit while any cause is latched
  always_ff @(posedge mclk) begin
    if (rst) begin
      alarmLed_q <= 1'b0;
    end else begin
      alarmLed_q <= alarmLed_d;
    end
  end

  // shutdown edge: one error report with its code, and a timed beep
  assign beepCnt_d = shutRise ? BEEP_LOAD :
                     (beepCnt_q != '0) ? beepCnt_q - 1'b1 : beepCnt_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      beepCnt_q <= '0;
      beepOn_q  <= 1'b0;
    end else begin
      beepCnt_q <= beepCnt_d;       // RULE11
      beepOn_q  <= beepCnt_d != '0; // RULE11
    end
  end

  // error report: one-cycle strobe, code held until the next error
  assign errorStrobe_d = shutRise;                                      // RULE11
  assign errorCode_d   = shutRise ? `OCS_ERR_SHUTDOWN : errorCode_q;    // RULE11

  always_ff @(posedge mclk) begin
    if (rst) begin
      errorStrobe_q <= 1'b0;
      errorCode_q   <= `OCS_ERR_NONE;
    end else begin
      errorStrobe_q <= errorStrobe_d;
      errorCode_q   <= errorCode_d;
    end
  end

  // recall from the port contact merges with the front key
  assign recallStrobe_d = unitOn & (settingsRecallKey | recallRise); // RULE1

  always_ff @(posedge mclk) begin
    if (rst) begin
      recallStrobe_q <= 1'b0;
    end else begin
      recallStrobe_q <= recallStrobe_d;
    end
  end

  // status lines built from state, then registered before the optocouplers
  assign status_d.poweredN = ~unitOn;                             // RULE2
  assign status_d.alarmN   = ~(|cause_q);                         // RULE3
  assign status_d.outOnN   = ~(onStatusEnable & outputEnable_q);  // RULE4
  assign status_d.ccN      = ~(outputEnable_q & constCurrentLoop);  // RULE5
  assign status_d.cvN      = ~(outputEnable_q & ~constCurrentLoop); // RULE6

  always_ff @(posedge mclk) begin
    if (rst) begin
      status_q <= `OCS_STATUS_IDLE;
    end else begin
      status_q <= status_d; // RULE15
    end
  end

  // 0-10 V codes stretched to full scale by bit replication: zero maps to zero,
  // the top code maps to the top reference code, with no divider needed
  assign extVoltScaled = {extVoltageProgramIn,
                          extVoltageProgramIn[`OCS_ADC_W-1 -: `OCS_REF_W-`OCS_ADC_W]};
  assign extCurrScaled = {extCurrentProgramIn,
                          extCurrentProgramIn[`OCS_ADC_W-1 -: `OCS_REF_W-`OCS_ADC_W]};

  // setpoint source: external analog when enabled, otherwise the panel value
  assign voltRef_d = extVoltageProgramEnable ? extVoltScaled : panelVoltSet; // RULE13
  assign currRef_d = extCurrentProgramEnable ? extCurrScaled : panelCurrSet; // RULE14

  // voltage reference register feeding the regulation loop
  always_ff @(posedge mclk) begin
    if (rst) begin
      voltRef_q <= '0;
    end else begin
      voltRef_q <= voltRef_d;
    end
  end

  // current reference register feeding the regulation loop
  always_ff @(posedge mclk) begin
    if (rst) begin
      currRef_q <= '0;
    end else begin
      currRef_q <= currRef_d;
    end
  end

  // outputs
  assign statusOut    = status_q;
  assign outputEnable = outputEnable_q;
  assign recallStrobe = recallStrobe_q;
  assign beepOn       = beepOn_q;
  assign alarmLedOn   = alarmLed_q;
  assign errorStrobe  = errorStrobe_q;
  assign errorCode    = errorCode_q;
  assign alarmCause   = cause_q;
  assign voltRef      = voltRef_q;
  assign currRef      = currRef_q;
endmodule

// ---- verif/ocs_port_asserts.sv ----
// checker for the output control and status port
`timescale 1ns/1ps
`include "ocs_params.svh"
module ocs_port_asserts #(
  parameter int DEBOUNCE_CYCLES = 4,
  parameter int BEEP_CYCLES     = 8
) (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  unitOn,
  input wire logic                  extOutputSwitchSetting,
  input wire logic                  onStatusEnable,
  input wire logic                  extVoltageProgramEnable,
  input wire logic                  extCurrentProgramEnable,
  input wire logic                  localOutputRequest,
  input wire logic                  settingsRecallKey,
  input wire logic                  overVoltageTrip,
  input wire logic                  constCurrentLoop,
  input wire logic [`OCS_ADC_W-1:0] extVoltageProgramIn,
  input wire logic [`OCS_ADC_W-1:0] extCurrentProgramIn,
  input wire logic [`OCS_REF_W-1:0] panelVoltSet,
  input wire logic [`OCS_REF_W-1:0] panelCurrSet,
  input wire ocs_pkg::ocs_status_t  statusOut,
  input wire logic                  outputEnable,
  input wire logic                  recallStrobe,
  input wire logic                  beepOn,
  input wire logic                  alarmLedOn,
  input wire logic                  errorStrobe,
  input wire logic [`OCS_ERR_W-1:0] errorCode,
  input wire ocs_pkg::ocs_cause_t   alarmCause,
  input wire logic [`OCS_REF_W-1:0] voltRef,
  input wire logic [`OCS_REF_W-1:0] currRef
);
  import ocs_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic             prevRst_q;
  logic [15:0]      vExp_q;
  logic [15:0]      cExp_q;
  // reset history and expected references, so registered relations skip reset
  always_ff @(posedge mclk) begin
    prevRst_q <= rst;
    vExp_q    <= extVoltageProgramEnable ? {extVoltageProgramIn, extVoltageProgramIn[11:8]}
                                         : panelVoltSet;
    cExp_q    <= extCurrentProgramEnable ? {extCurrentProgramIn, extCurrentProgramIn[11:8]}
                                         : panelCurrSet;
  end
  property p_pwr; !prevRst_q |-> statusOut.poweredN == !$past(unitOn); endproperty
  a_pwr: assert property (p_pwr) else $error("powered line wrong");
  property p_alm; !prevRst_q |-> statusOut.alarmN == !(|$past(alarmCause)); endproperty
  a_alm: assert property (p_alm) else $error("alarm line wrong");
  property p_onst;
    !prevRst_q |-> statusOut.outOnN == !($past(onStatusEnable) && $past(outputEnable));
  endproperty
  a_onst: assert property (p_onst) else $error("output-on line wrong");
  property p_cc;
    !prevRst_q |-> statusOut.ccN == !($past(outputEnable) && $past(constCurrentLoop));
  endproperty
  a_cc: assert property (p_cc) else $error("cc line wrong");
  property p_cv;
    !prevRst_q |-> statusOut.cvN == !($past(outputEnable) && !$past(constCurrentLoop));
  endproperty
  a_cv: assert property (p_cv) else $error("cv line wrong");
  property p_rcl; settingsRecallKey && unitOn |=> recallStrobe ##1 !recallStrobe; endproperty
  a_rcl: assert property (p_rcl) else $error("recall pulse wrong");
  property p_shut;
    $rose(alarmCause.shutdown) |-> !outputEnable && errorStrobe && errorCode == 8'h4d
      && alarmLedOn && beepOn;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown effects wrong");
  property p_pri; alarmCause.shutdown |-> !outputEnable; endproperty
  a_pri: assert property (p_pri) else $error("output on under shutdown");
  property p_ign;
    !$past(extOutputSwitchSetting) && !$past(localOutputRequest) |-> !outputEnable;
  endproperty
  a_ign: assert property (p_ign) else $error("output on without request");
  property p_trip; overVoltageTrip |=> alarmCause.overVoltage && alarmLedOn && !outputEnable;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not latched");
  property p_vref; !prevRst_q |-> voltRef == vExp_q; endproperty
  a_vref: assert property (p_vref) else $error("voltage reference wrong");
  property p_cref; !prevRst_q |-> currRef == cExp_q; endproperty
  a_cref: assert property (p_cref) else $error("current reference wrong");
endmodule

bind ocs_port ocs_port_asserts #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
  .BEEP_CYCLES    (BEEP_CYCLES)
) u_asserts (.*);

// ---- verif/ocs_ext_ctrl.sv ----
// model of the external controller and relay contacts on the port
`timescale 1ns/1ps
module ocs_ext_ctrl (
  input  wire logic         recallClosed,
  input  wire logic         isoApplied,
  input  wire logic         contactClosed,
  input  wire logic         shutShorted,
  output ocs_pkg::ocs_pins_t pins
);
  import ocs_pkg::*;
  // dry contacts pull low when closed, the isolated input is a positive level
  assign pins.recallN   = !recallClosed;
  assign pins.isoOn     = isoApplied;
  assign pins.contactN  = !contactClosed;
  assign pins.shutdownN = !shutShorted;
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the output control and status port
`timescale 1ns/1ps
`include "ocs_params.svh"
module testbench;
  import ocs_pkg::*;
  localparam int DB = 4;
  localparam int BP = 8;
  logic        mclk, rst, unitOn, extSet, onStEn, vEn, cEn, locReq, key, ovt, oct, clr, ccLoop;
  logic        settings_recall_key, iso, con, sht, oe, rs, beep, led, es;
  logic [11:0] vAdc, cAdc;
  logic [15:0] vPan, cPan, vRef, cRef, lf;
  logic [7:0]  ec;
  ocs_pins_t   pins;
  ocs_status_t st;
  ocs_cause_t  cause;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cnt;

  ocs_ext_ctrl u_far (.recallClosed(settings_recall_key), .isoApplied(iso), .contactClosed(con),
    .shutShorted(sht), .pins(pins));
  ocs_port #(.DEBOUNCE_CYCLES(DB), .BEEP_CYCLES(BP)) uut (.mclk(mclk), .rst(rst),
    .pinIn(pins), .unitOn(unitOn), .extOutputSwitchSetting(extSet), .onStatusEnable(onStEn),
    .extVoltageProgramEnable(vEn), .extCurrentProgramEnable(cEn), .localOutputRequest(locReq),
    .settingsRecallKey(key), .overVoltageTrip(ovt), .overCurrentTrip(oct), .alarmClear(clr),
    .constCurrentLoop(ccLoop), .extVoltageProgramIn(vAdc), .extCurrentProgramIn(cAdc),
    .panelVoltSet(vPan), .panelCurrSet(cPan), .statusOut(st), .outputEnable(oe),
    .recallStrobe(rs), .beepOn(beep), .alarmLedOn(led), .errorStrobe(es), .errorCode(ec),
    .alarmCause(cause), .voltRef(vRef), .currRef(cRef));

  // free-running clock
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] refv(input logic e, input logic [11:0] a, input logic [15:0] p);
    return e ? {a, a[11:8]} : p;
  endfunction
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    n_tests++;
    if (a !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  // bounded wait for the output state, then compare
  task automatic waitOe(input logic e);
    for (int i = 0; i < 30 && oe !== e; i++) step(1);
    chk(e, oe);
    if (oe !== e) end_of_test();
  endtask

  // main sequence
  initial begin
    {rst, unitOn, extSet, onStEn, vEn, cEn, locReq, key, ovt, oct, clr, ccLoop} = 12'h800;
    {settings_recall_key, iso, con, sht} = 4'h0;
    {vAdc, cAdc, vPan, cPan} = '0;
    lf = 16'h004c;
    step(2);
    chk(5'h1f, st);
    rst = 0;
    for (int k = 0; k < 8; k++) begin
      lf = nxt(lf);
      vAdc = (k == 0) ? 12'hfff : lf[11:0];
      vEn = (k < 2) | lf[12];
      vPan = ~lf;
      lf = nxt(lf);
      cAdc = (k == 1) ? 12'hfff : lf[11:0];
      cEn = (k < 2) | lf[13];
      cPan = lf;
      step(1);
      chk(refv(vEn, vAdc, vPan), vRef);
      chk(refv(cEn, cAdc, cPan), cRef);
    end
    unitOn = 1;
    ccLoop = 1;
    onStEn = 1;
    step(2);
    chk(0, st.poweredN);
    locReq = 1;
    waitOe(1);
    extSet = 1;
    waitOe(0);
    con = 1;
    waitOe(1);
    step(2);
    chk(5'h09, st);
    con = 0;
    step(2);
    con = 1;
    step(DB + 8);
    chk(1, oe);
    con = 0;
    waitOe(0);
    iso = 1;
    waitOe(1);
    con = 1;
    step(DB + 8);
    iso = 0;
    step(DB + 8);
    chk(1, oe);
    ccLoop = 0;
    step(2);
    chk(5'h0a, st);
    onStEn = 0;
    step(2);
    chk(5'h0e, st);
    sht = 1;
    waitOe(0);
    chk(8'h4d, ec);
    chk(1, led);
    chk(1, es);
    chk(1, beep);
    step(1);
    chk(0, st.alarmN);
    chk(0, es);
    step(BP - 2);
    chk(1, beep);
    step(1);
    chk(0, beep);
    sht = 0;
    step(DB + 8);
    chk(0, oe);
    clr = 1;
    step(1);
    clr = 0;
    waitOe(1);
    for (int j = 0; j < 2; j++) begin
      ovt = (j == 0);
      oct = (j == 1);
      step(1);
      {ovt, oct} = 2'h0;
      chk(j ? 3'h2 : 3'h4, cause);
      chk(0, oe);
      clr = 1;
      step(1);
      clr = 0;
      waitOe(1);
    end
    // contact still closed: it must be ignored once the setting is off
    {extSet, locReq} = 2'h0;
    waitOe(0);
    extSet = 1;
    waitOe(1);
    key = 1;
    step(1);
    key = 0;
    chk(1, rs);
    settings_recall_key = 1;
    cnt = 0;
    repeat (DB + 12) begin
      step(1);
      cnt += rs;
    end
    chk(1, cnt);
    unitOn = 0;
    key = 1;
    step(1);
    key = 0;
    chk(0, rs);
    chk(1, st.poweredN);
    end_of_test();
  end
endmodule
